/* File: hdl/pwr_regs_consts.vh */
/*
  Constants for the paged result and configuration register bank:
  page numbers, register addresses, field positions, reset values and
  arithmetic widths.
  Assumes it is included by its bare name from the design files.
*/
`ifndef PWR_REGS_CONSTS_VH
`define PWR_REGS_CONSTS_VH

`define WORD_W 24
`define ADDR_W 5
`define PAGE_W 7

`define PAGE_BASE 7'h00
`define PAGE_CONFIG 7'h01

`define ADDR_APPARENT 5'h1B
`define ADDR_CONTROL 5'h1C
`define ADDR_HARMONIC 5'h1D
`define ADDR_FUND_ACTIVE 5'h1E
`define ADDR_FUND_REACTIVE 5'h1F
`define ADDR_PAGE 5'h1F
`define ADDR_PULSE_WIDTH 5'h00
`define ADDR_NO_LOAD 5'h01
`define ADDR_TEMP_GAIN 5'h02

`define CTRL_OSC_OFF_BIT 1
`define CTRL_CLK_OFF_BIT 2
`define CTRL_OPEN_DRAIN_BIT 4
`define CTRL_BOOT_HALT_BIT 8
`define CTRL_WRITE_MASK 24'h000116

`define RST_PULSE_WIDTH 24'h000001
`define RST_NO_LOAD 24'h000000
`define RST_TEMP_GAIN 24'h2F03C3
`define RST_CONTROL 24'h000000
`define RST_PAGE 7'h00

`define PULSE_WIDTH_MIN 24'h000001
`define PULSE_WIDTH_MAX 24'h7FFFFF
`define TEMP_GAIN_FRAC 17

`endif

/* File: hdl/fixed_mult.v */
/*
  Registered fixed point multiplier used by the result registers.
  Takes two fractional operands of equal width and returns the product
  rescaled to the operand format, one cycle after the load strobe.
  Assumes the inputs are stable during the load strobe.
*/
`timescale 1ns/10ps
`default_nettype none

module fixed_mult #(
  parameter W = 24,
  parameter SIGNED = 1,
  parameter FRAC = 23
) (
  input wire clk,
  input wire reset,
  input wire load,
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  output reg [W-1:0] product
);

  wire signed [W:0] a_ext;
  wire signed [W:0] b_ext;
  wire signed [2*W+1:0] full;
  wire [W-1:0] scaled;

  // Extend operands to signed, with zero extension for unsigned use.
  assign a_ext = SIGNED ? {a[W-1], a} : {1'b0, a};
  assign b_ext = SIGNED ? {b[W-1], b} : {1'b0, b};
  assign full = a_ext * b_ext;
  assign scaled = full[FRAC+W-1:FRAC];

  // Capture the rescaled product on each load strobe.
  always @(posedge clk) begin
    if (reset) begin
      product <= {W{1'b0}};
    end else if (load) begin
      product <= scaled;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/power_meter_result_and_config_regs.v */
/*
  Paged register bank for a single phase power measurement device.
  Holds the apparent, harmonic active and fundamental power results,
  the control register, the page register and three page 1 settings,
  and drives the energy pulse, the host clock gate and the oscillator.
  Assumes measurement inputs are synchronous to clk and valid when
  result_strobe pulses; output_word_rate pulses once per output word.
*/
`timescale 1ns/10ps
`default_nettype none

`include "pwr_regs_consts.vh"

// What this block does
// - Apparent power is unsigned product Vrms times Irms.
// - Control bit 8 halts auto-boot sequence.
// - Control bit 4 makes interrupt pin open drain.
// - Control bit 2 stops host clock output.
// - Control bit 1 stops crystal oscillator.
// - Harmonic power equals total minus fundamental active.
// - Fundamental active is product of DFT results.
// - Address 31 reads fundamental reactive power.
// - Write to 31 loads seven-bit page select.
// - Pulse lasts width register over word rate.
// - Pulses suppressed while active power magnitude below threshold.
// - Temperature result scaled by unsigned temperature gain.
module power_meter_result_and_config_regs #(
  parameter W = `WORD_W,
  parameter AW = `ADDR_W,
  parameter PW = `PAGE_W
) (
  input wire clk,
  input wire reset,
  input wire reg_write,
  input wire reg_read,
  input wire [AW-1:0] reg_addr,
  input wire [W-1:0] reg_wdata,
  output reg [W-1:0] reg_rdata,
  output reg reg_rvalid,
  input wire result_strobe,
  input wire [W-1:0] v_rms,
  input wire [W-1:0] i_rms,
  input wire [W-1:0] active_power_result,
  input wire [W-1:0] v_fund_re,
  input wire [W-1:0] v_fund_im,
  input wire [W-1:0] i_fund_re,
  input wire [W-1:0] i_fund_im,
  input wire [W-1:0] temp_raw,
  input wire output_word_rate,
  input wire energy_pulse_req,
  input wire irq_request,
  input wire host_clock_in,
  output reg energy_pulse,
  output wire [W-1:0] temp_scaled,
  output wire [PW-1:0] page_select,
  output wire auto_boot_halt,
  output wire irq_out,
  output wire irq_oe,
  output wire host_clock_out_pin,
  output wire crystal_osc_disable
);

  reg [W-1:0] device_control;
  reg [PW-1:0] page_reg;
  reg [W-1:0] energy_pulse_width;
  reg [W-1:0] no_load_threshold;
  reg [W-1:0] temperature_gain;
  reg [W-1:0] harmonic_active_power_result;
  reg [W-1:0] fundamental_active_power_result;
  reg [W-1:0] fundamental_reactive_power_result;
  reg strobe_d;
  reg [W-1:0] pulse_count;
  reg [W-1:0] next_rdata;
  wire [W-1:0] apparent_power_result;
  wire [W-1:0] vr_ir;
  wire [W-1:0] vi_ii;
  wire [W-1:0] vr_ii;
  wire [W-1:0] vi_ir;
  wire irq_open_drain_sel;
  wire host_clock_out_disable;
  wire [W-1:0] active_mag;
  wire below_threshold;
  wire [2*W-1:0] temp_full;

  // Address decode: true when the access hits addr on the given page.
  function hit;
    input [AW-1:0] addr;
    input [PW-1:0] page;
    input [AW-1:0] want_addr;
    input [PW-1:0] want_page;
    begin
      hit = (addr == want_addr) && (page == want_page);
    end
  endfunction

  // Apparent power from the two RMS results, unsigned fraction.
  fixed_mult #(.W(W), .SIGNED(0), .FRAC(W-1)) u_apparent (
    .clk(clk),
    .reset(reset),
    .load(result_strobe),
    .a(v_rms),
    .b(i_rms),
    .product(apparent_power_result)
  );

  // Cross products of the single frequency transforms of V and I.
  fixed_mult #(.W(W), .SIGNED(1), .FRAC(W-1)) u_rr (
    .clk(clk),
    .reset(reset),
    .load(result_strobe),
    .a(v_fund_re),
    .b(i_fund_re),
    .product(vr_ir)
  );
  fixed_mult #(.W(W), .SIGNED(1), .FRAC(W-1)) u_ii (
    .clk(clk),
    .reset(reset),
    .load(result_strobe),
    .a(v_fund_im),
    .b(i_fund_im),
    .product(vi_ii)
  );
  fixed_mult #(.W(W), .SIGNED(1), .FRAC(W-1)) u_ri (
    .clk(clk),
    .reset(reset),
    .load(result_strobe),
    .a(v_fund_re),
    .b(i_fund_im),
    .product(vr_ii)
  );
  fixed_mult #(.W(W), .SIGNED(1), .FRAC(W-1)) u_ir (
    .clk(clk),
    .reset(reset),
    .load(result_strobe),
    .a(v_fund_im),
    .b(i_fund_re),
    .product(vi_ir)
  );

  // Combine the products one cycle after the strobe into the results.
  always @(posedge clk) begin
    if (reset) begin
      strobe_d <= 1'b0;
      fundamental_active_power_result <= {W{1'b0}};
      fundamental_reactive_power_result <= {W{1'b0}};
      harmonic_active_power_result <= {W{1'b0}};
    end else begin
      strobe_d <= result_strobe;
      if (strobe_d) begin
        fundamental_active_power_result <= vr_ir + vi_ii;
        fundamental_reactive_power_result <= vi_ir - vr_ii;
        harmonic_active_power_result <=
          active_power_result - (vr_ir + vi_ii);
      end
    end
  end

  // Register writes; result locations take no write data.
  always @(posedge clk) begin
    if (reset) begin
      device_control <= `RST_CONTROL;
      page_reg <= `RST_PAGE;
      energy_pulse_width <= `RST_PULSE_WIDTH;
      no_load_threshold <= `RST_NO_LOAD;
      temperature_gain <= `RST_TEMP_GAIN;
    end else if (reg_write) begin
      if (reg_addr == `ADDR_PAGE) begin
        page_reg <= reg_wdata[PW-1:0];
      end
      if (hit(reg_addr, page_reg, `ADDR_CONTROL, `PAGE_BASE)) begin
        device_control <= reg_wdata & `CTRL_WRITE_MASK;
      end
      if (hit(reg_addr, page_reg, `ADDR_PULSE_WIDTH, `PAGE_CONFIG)) begin
        if (reg_wdata[W-1] || reg_wdata == {W{1'b0}}) begin
          energy_pulse_width <= `PULSE_WIDTH_MIN;
        end else begin
          energy_pulse_width <= reg_wdata;
        end
      end
      if (hit(reg_addr, page_reg, `ADDR_NO_LOAD, `PAGE_CONFIG)) begin
        no_load_threshold <= reg_wdata;
      end
      if (hit(reg_addr, page_reg, `ADDR_TEMP_GAIN, `PAGE_CONFIG)) begin
        temperature_gain <= reg_wdata;
      end
    end
  end

  // Read mux decoded against the current page, except address 31, which reads on every page.
  always @* begin
    next_rdata = {W{1'b0}};
    if (reg_addr == `ADDR_FUND_REACTIVE) begin
      next_rdata = fundamental_reactive_power_result;
    end else if (hit(reg_addr, page_reg, `ADDR_APPARENT, `PAGE_BASE)) begin
      next_rdata = apparent_power_result;
    end else if (hit(reg_addr, page_reg, `ADDR_CONTROL, `PAGE_BASE)) begin
      next_rdata = device_control;
    end else if (hit(reg_addr, page_reg, `ADDR_HARMONIC, `PAGE_BASE)) begin
      next_rdata = harmonic_active_power_result;
    end else if (hit(reg_addr, page_reg, `ADDR_FUND_ACTIVE,
                     `PAGE_BASE)) begin
      next_rdata = fundamental_active_power_result;
    end else if (hit(reg_addr, page_reg, `ADDR_PULSE_WIDTH,
                     `PAGE_CONFIG)) begin
      next_rdata = energy_pulse_width;
    end else if (hit(reg_addr, page_reg, `ADDR_NO_LOAD, `PAGE_CONFIG)) begin
      next_rdata = no_load_threshold;
    end else if (hit(reg_addr, page_reg, `ADDR_TEMP_GAIN, `PAGE_CONFIG)) begin
      next_rdata = temperature_gain;
    end
  end

  // Read data is registered and marked valid one cycle after the read.
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= {W{1'b0}};
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Control bit decode onto the pins it steers.
  assign auto_boot_halt = device_control[`CTRL_BOOT_HALT_BIT];
  assign irq_open_drain_sel = device_control[`CTRL_OPEN_DRAIN_BIT];
  assign host_clock_out_disable = device_control[`CTRL_CLK_OFF_BIT];
  assign crystal_osc_disable = device_control[`CTRL_OSC_OFF_BIT];
  assign page_select = page_reg;

  // Open drain drives only low; push-pull drives both levels.
  assign irq_out = irq_open_drain_sel ? 1'b0 : irq_request;
  assign irq_oe = irq_open_drain_sel ? ~irq_request : 1'b1;

  // Host clock held low while disabled.
  assign host_clock_out_pin = host_clock_in & ~host_clock_out_disable;

  // Magnitude of active power compared with the no-load threshold.
  assign active_mag = active_power_result[W-1] ?
                      (~active_power_result + {{(W-1){1'b0}}, 1'b1}) :
                      active_power_result;
  assign below_threshold = active_mag < no_load_threshold;

  // Pulse generator: width counted in output words.
  always @(posedge clk) begin
    if (reset) begin
      pulse_count <= {W{1'b0}};
      energy_pulse <= 1'b0;
    end else if (below_threshold) begin
      pulse_count <= {W{1'b0}};
      energy_pulse <= 1'b0;
    end else if (!energy_pulse && energy_pulse_req) begin
      pulse_count <= energy_pulse_width;
      energy_pulse <= 1'b1;
    end else if (energy_pulse && output_word_rate) begin
      if (pulse_count <= {{(W-1){1'b0}}, 1'b1}) begin
        pulse_count <= {W{1'b0}};
        energy_pulse <= 1'b0;
      end else begin
        pulse_count <= pulse_count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Temperature scaled by the unsigned gain, seven integer bits.
  assign temp_full = temp_raw * temperature_gain;
  assign temp_scaled = temp_full[`TEMP_GAIN_FRAC+W-1:`TEMP_GAIN_FRAC];

endmodule

`default_nettype wire

/* File: tb/pwr_regs_assertions.sv */
/*
  Port checker for the paged result and configuration register bank.
  Assumes it is bound to the bank's top module and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module pwr_regs_checker (
  input wire clk,
  input wire reset,
  input wire reg_write,
  input wire reg_read,
  input wire [4:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_rvalid,
  input wire energy_pulse_req,
  input wire energy_pulse,
  input wire [6:0] page_select,
  input wire auto_boot_halt,
  input wire host_clock_out_pin,
  input wire crystal_osc_disable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic clk_off;
  // Decoded write strobes and the data fields they load.
  wire ctl_wr = reg_write && reg_addr == 5'h1C && page_select == 7'h00;
  wire [6:0] w_page = reg_wdata[6:0];
  wire w_halt = reg_wdata[8];
  wire w_osc = reg_wdata[1];
  // Shadow of the host clock disable bit, so the pin can be judged.
  always @(posedge clk) begin
    if (reset) begin
      clk_off <= 1'b0;
    end else if (ctl_wr) begin
      clk_off <= reg_wdata[2];
    end
  end
  // A write that lands in the page register.
  sequence page_wr;
    reg_write && reg_addr == 5'h1F;
  endsequence
  // A cycle with no page register write.
  sequence page_kept;
    !(reg_write && reg_addr == 5'h1F);
  endsequence
  // A write that lands in the control register.
  sequence ctl_wr_s;
    ctl_wr;
  endsequence
  AST_RD_ANSWER:
    assert property (reg_read |=> reg_rvalid)
    else $error("read not answered next cycle");
  AST_RVALID_CAUSE:
    assert property (reg_rvalid |-> $past(reg_read))
    else $error("read valid without a read");
  AST_PAGE_LOAD:
    assert property (page_wr |=> page_select == $past(w_page))
    else $error("page not loaded");
  AST_PAGE_HOLD:
    assert property (page_kept |=> $stable(page_select))
    else $error("page changed without a write");
  AST_HALT:
    assert property (ctl_wr_s |=> auto_boot_halt == $past(w_halt))
    else $error("halt bit not loaded");
  AST_OSC:
    assert property (ctl_wr_s |=> crystal_osc_disable == $past(w_osc))
    else $error("oscillator bit not loaded");
  AST_HOST_CLK:
    assert property (clk_off |-> !host_clock_out_pin)
    else $error("host clock driven while disabled");
  AST_PULSE_CAUSE:
    assert property ($rose(energy_pulse) |-> $past(energy_pulse_req))
    else $error("pulse without request");
  AST_RESET:
    assert property (disable iff (1'b0)
      reset |=> page_select == 7'h00 && !auto_boot_halt &&
      !crystal_osc_disable && !energy_pulse)
    else $error("reset values wrong");
endmodule

`default_nettype wire

/* File: tb/pwr_host_model.sv */
/*
  Host processor model that reaches the register bank.
  Assumes the bench calls wr and rd; it changes signals at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none

module pwr_host_model (
  input wire clk,
  output logic reg_write,
  output logic reg_read,
  output logic [4:0] reg_addr,
  output logic [23:0] reg_wdata,
  input wire [23:0] reg_rdata,
  input wire reg_rvalid
);
  // Idle bus at time zero.
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
  end
  // One write; afterwards the lines show inverted values, not stale ones.
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // One read; waits a bounded time for the answer.
  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    for (int n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk);
    d = reg_rdata;
    reg_addr = ~a;
  endtask
endmodule

`default_nettype wire

/* File: tb/power_meter_result_and_config_regs_tb.sv */
/*
  Self-checking bench for the paged register bank.
  Assumes the host model and the checker are compiled beforehand.
*/
`timescale 1ns/10ps
`default_nettype none

module power_meter_result_and_config_regs_tb;
  logic clk, reset, result_strobe, output_word_rate, energy_pulse_req;
  logic irq_request, host_clock_in;
  logic [23:0] v_rms, i_rms, active_power_result, v_fund_re, v_fund_im;
  logic [23:0] i_fund_re, i_fund_im, temp_raw, got;
  wire reg_write, reg_read, reg_rvalid, energy_pulse, auto_boot_halt;
  wire irq_out, irq_oe, host_clock_out_pin, crystal_osc_disable;
  wire [4:0] reg_addr;
  wire [23:0] reg_wdata, reg_rdata, temp_scaled;
  wire [6:0] page_select;
  int fails = 0;
  int cmp_count = 0;
  int k;
  power_meter_result_and_config_regs power_meter_result_and_config_regs_i (.*);
  pwr_host_model pwr_host_model_i (.*);
  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [23:0] e);
    pwr_host_model_i.rd(a, got);
    chk(got, e);
  endtask
  // Requests a pulse, then counts word-rate ticks seen while it is high.
  task automatic burst(output int n);
    @(negedge clk) energy_pulse_req = 1'b1;
    @(negedge clk) energy_pulse_req = 1'b0;
    n = 0;
    repeat (8) begin
      if (energy_pulse === 1'b1) n++;
      @(negedge clk) output_word_rate = 1'b1;
      @(negedge clk) output_word_rate = 1'b0;
    end
  endtask
  task automatic test_done;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #400000;
    fails++;
    test_done;
  end
  // Main sequence.
  initial begin
    {reset, result_strobe, output_word_rate, energy_pulse_req} = 4'h8;
    {irq_request, host_clock_in} = 2'h3;
    {v_rms, i_rms, active_power_result} = {3{24'h400000}};
    {v_fund_re, v_fund_im, i_fund_re} = {24'h400000, 24'h200000, 24'h400000};
    {i_fund_im, temp_raw} = {24'h000000, 24'h123456};
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk(24'(page_select), 24'h000000);
    rchk(5'h1C, 24'h000000);
    chk(24'(host_clock_out_pin), 24'h000001);
    chk(24'({irq_out, irq_oe}), 24'h000003);
    pwr_host_model_i.wr(5'h1C, 24'hFFFFFF);
    rchk(5'h1C, 24'h000116);
    chk(24'(auto_boot_halt), 24'h000001);
    chk(24'(crystal_osc_disable), 24'h000001);
    chk(24'(host_clock_out_pin), 24'h000000);
    chk(24'({irq_out, irq_oe}), 24'h000000);
    @(negedge clk) irq_request = 1'b0;
    @(posedge clk);
    chk(24'({irq_out, irq_oe}), 24'h000001);
    rchk(5'h00, 24'h000000);
    pwr_host_model_i.wr(5'h1F, 24'hFFFF81);
    chk(24'(page_select), 24'h000001);
    rchk(5'h1C, 24'h000000);
    rchk(5'h00, 24'h000001);
    rchk(5'h01, 24'h000000);
    rchk(5'h02, 24'h2F03C3);
    pwr_host_model_i.wr(5'h02, 24'h020000);
    chk(temp_scaled, 24'h123456);
    pwr_host_model_i.wr(5'h00, 24'h7FFFFF);
    rchk(5'h00, 24'h7FFFFF);
    pwr_host_model_i.wr(5'h00, 24'h000003);
    burst(k);
    chk(24'(k), 24'h000003);
    pwr_host_model_i.wr(5'h01, 24'h200000);
    active_power_result = 24'h100000;
    burst(k);
    chk(24'(k), 24'h000000);
    active_power_result = 24'hF00000;
    burst(k);
    chk(24'(k), 24'h000000);
    active_power_result = 24'hE00000;
    burst(k);
    chk(24'(k), 24'h000003);
    pwr_host_model_i.wr(5'h1F, 24'h000000);
    @(negedge clk) result_strobe = 1'b1;
    @(negedge clk) result_strobe = 1'b0;
    repeat (3) @(negedge clk);
    for (int j = 0; j < 2; j++) begin
      rchk(5'h1B, 24'h200000);
      rchk(5'h1D, 24'hC00000);
      rchk(5'h1E, 24'h200000);
      rchk(5'h1F, 24'h100000);
      pwr_host_model_i.wr(5'h1B, 24'h5A5A5A);
      pwr_host_model_i.wr(5'h1D, 24'h5A5A5A);
      pwr_host_model_i.wr(5'h1E, 24'h5A5A5A);
    end
    // Second reset in mid-run: page, control bits, control register and apparent result must return to their defaults.
    @(negedge clk) reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk(24'(page_select), 24'h000000);
    chk(24'(host_clock_out_pin), 24'h000001);
    chk(24'(crystal_osc_disable), 24'h000000);
    chk(24'(auto_boot_halt), 24'h000000);
    rchk(5'h1C, 24'h000000);
    rchk(5'h1B, 24'h000000);
    test_done;
  end
endmodule

bind power_meter_result_and_config_regs pwr_regs_checker chk_i (.*);

`default_nettype wire
